// File: design/vmc_pkg.sv
// Constants, types and helpers shared by the voltage memory controller.
// Assumes a 25 MHz system clock and magnitudes in 0.01 V, angles in 0.01 deg.

package vmc_pkg;

    // ==========================================================
    // Widths
    localparam int NCH = 3;
    localparam int VW  = 16;
    localparam int AW  = 16;
    localparam int FW  = 17;
    localparam int TW  = 13;
    localparam int SCW = 24;

    // ==========================================================
    // Setting limits, voltages in 0.01 V, hold time in 10 ms steps
    localparam logic [VW-1:0] ACT_V_MIN = 16'h00C8;
    localparam logic [VW-1:0] ACT_V_MAX = 16'h1388;
    localparam logic [VW-1:0] HOLD_MIN  = 16'h0002;
    localparam logic [VW-1:0] HOLD_MAX  = 16'h1388;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS     = 40;
    localparam int HOLD_STEP_NS      = 10000000;
    localparam int HOLD_STEP_CYCLES  = HOLD_STEP_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Event bit positions
    localparam int EV_ENABLED = 0;
    localparam int EV_VLOW    = 1;
    localparam int EV_IHIGH   = 2;
    localparam int EV_FCT     = 3;
    localparam int EV_INUSE   = 4;
    localparam int EV_BLOCKED = 5;
    localparam int NEV        = 6;

    typedef enum logic [1:0] {VMC_IDLE, VMC_ACTIVE, VMC_EXPIRED} vmc_state_t;

    typedef logic [NCH-1:0][VW-1:0] vmc_mag_t;

    // Settings outside the allowed span are pulled to its nearest end
    function automatic logic [VW-1:0] vmc_clamp(input logic [VW-1:0] v,
                                                input logic [VW-1:0] lo,
                                                input logic [VW-1:0] hi);
        logic [VW-1:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

endpackage

// File: design/vmc_link_if.sv
// Signals passed between the controller core and its two helper modules.
// Assumes all three sit on the same clock.

interface vmc_link_if;
    import vmc_pkg::*;

    logic           volt_low;
    logic           cur_high;
    logic [NEV-1:0] levels;
    logic [NEV-1:0] ev_on;
    logic [NEV-1:0] ev_off;

    modport cond (output volt_low, output cur_high);
    modport evt  (input levels, output ev_on, output ev_off);
    modport core (input volt_low, input cur_high, input ev_on, input ev_off, output levels);
endinterface

// File: design/vmc_cond.sv
// Voltage-low and current-high detection over the three channels.
// Assumes magnitudes and thresholds share one unit; purely combinational.

module vmc_cond
    import vmc_pkg::*;
(
    vmc_link_if.cond                 link,
    input  wire vmc_pkg::vmc_mag_t   volt_mag,
    input  wire logic [vmc_pkg::NCH-1:0] volt_used,
    input  wire logic [vmc_pkg::VW-1:0]  volt_thr,
    input  wire vmc_pkg::vmc_mag_t   cur_mag,
    input  wire logic [vmc_pkg::VW-1:0]  cur_pickup
);

    // ==========================================================
    // Per channel compare
    logic [NCH-1:0] below_ok;
    logic [NCH-1:0] above;

    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            // Unused channels never veto the low-voltage decision
            assign below_ok[i] = ~volt_used[i] | (volt_mag[i] < volt_thr);
            assign above[i]    = cur_mag[i] > cur_pickup;
        end
    endgenerate

    // No used channel at all means nothing is measured, so no memory
    assign link.volt_low = (|volt_used) & (&below_ok);
    assign link.cur_high = |above;

endmodule

// File: design/vmc_evt.sv
// On and off event pulses from the controller's status levels.
// Assumes levels change only on clock edges; pulses last one clock.

module vmc_evt
    import vmc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    vmc_link_if.evt   link
);

    // ==========================================================
    // Edge detection
    logic [NEV-1:0] prev_ff;
    logic [NEV-1:0] on_ff;
    logic [NEV-1:0] off_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= link.levels;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NEV; i++) begin : g_ev
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    on_ff[i]  <= 1'b0;
                    off_ff[i] <= 1'b0;
                end else begin
                    on_ff[i]  <= link.levels[i] & ~prev_ff[i];
                    off_ff[i] <= ~link.levels[i] & prev_ff[i];
                end
            end
        end
    endgenerate

    assign link.ev_on  = on_ff;
    assign link.ev_off = off_ff;

endmodule

// File: design/vmc_pre_fault_reference_hold.sv
// Voltage memory controller: substitute voltage reference during close-in faults.
// Assumes cycle_start pulses one clock at the start of each program cycle and that
// measurement inputs are stable and synchronous to clk.
// Out-of-range settings are clamped to their spans rather than refused.

// Overview of operation
// - Voltage condition met only if every used voltage lies below threshold.
// - Optional current condition also needs one phase current above pick-up.
// - Conditions count toward start, keep and tracking only while enabled; disabled blocks any start and ends memory at the next strobe.
// - While active, reference amplitude equals the activation voltage setting.
// - Angle from just before activation is held as reference while active.
// - Memory-active output stays high while memory is in use.
// - Blocking input sampled once per program cycle start, used that cycle.
// - Activation threshold adjustable from 2 to 50 V, compared per voltage.
// - Definite-time limit 0.02 to 50 s starts when memory activates.
// - On expiry reference stops and stages fall back to non-directional.
// - Forced tracking with voltages gone takes frequency from third phase current.
// - Otherwise sampling uses the fixed system frequency setting.
// - On/off events for low voltage, high current, current-based tracking.
// - Events for enable/disable, memory in use, and blocking.
module vmc_pre_fault_reference_hold
    import vmc_pkg::*;
#(
    parameter int HOLD_STEP_CLKS = vmc_pkg::HOLD_STEP_CYCLES
)
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     cycle_start,
    input  wire logic                     mem_enable,
    input  wire logic                     line_to_line_sel,
    input  wire vmc_pkg::vmc_mag_t        volt_ll_mag,
    input  wire vmc_pkg::vmc_mag_t        volt_ln_mag,
    input  wire logic [vmc_pkg::NCH-1:0]  volt_used,
    input  wire logic [vmc_pkg::AW-1:0]   volt_ang_live,
    input  wire vmc_pkg::vmc_mag_t        cur_mag,
    input  wire logic                     phase_overcurrent_condition,
    input  wire logic [vmc_pkg::VW-1:0]   cur_pickup,
    input  wire logic [vmc_pkg::VW-1:0]   act_volt_set,
    input  wire logic [vmc_pkg::TW-1:0]   hold_time_limit,
    input  wire logic                     forced_ct_tracking,
    input  wire logic [vmc_pkg::FW-1:0]   fixed_freq,
    input  wire logic [vmc_pkg::FW-1:0]   third_phase_current_freq,
    input  wire logic                     block_in,
    output logic                          mem_active_ff,
    output logic [vmc_pkg::VW-1:0]        ref_amp_ff,
    output logic [vmc_pkg::AW-1:0]        ref_ang_ff,
    output logic                          nondir_fallback_ff,
    output logic                          block_sampled_ff,
    output logic                          freq_from_ct_ff,
    output logic [vmc_pkg::FW-1:0]        sample_freq_ff,
    output logic [vmc_pkg::NEV-1:0]       vt_module_event_block_on,
    output logic [vmc_pkg::NEV-1:0]       vt_module_event_block_off
);
    import vmc_pkg::*;

    // ==========================================================
    // Settings and helpers
    vmc_link_if link ();

    logic [VW-1:0]  volt_thr;
    logic [VW-1:0]  hold_lim_full;
    logic [TW-1:0]  hold_lim;
    vmc_mag_t       sel_mag;

    assign volt_thr      = vmc_clamp(act_volt_set, ACT_V_MIN, ACT_V_MAX);
    assign hold_lim_full = vmc_clamp({3'h0, hold_time_limit}, HOLD_MIN, HOLD_MAX);
    assign hold_lim      = hold_lim_full[TW-1:0];
    assign sel_mag  = line_to_line_sel ? volt_ll_mag : volt_ln_mag;

    vmc_cond u_cond (
        .link       (link.cond),
        .volt_mag   (sel_mag),
        .volt_used  (volt_used),
        .volt_thr   (volt_thr),
        .cur_mag    (cur_mag),
        .cur_pickup (cur_pickup)
    );

    // ==========================================================
    // Per program cycle decisions
    logic act_ok;
    logic keep_ok;

    // Shared by the start and the keep decisions
    function automatic logic vmc_hold_cond(input logic en,
                                           input logic low,
                                           input logic blk);
        return en & low & ~blk;
    endfunction

    // Block input read directly at the strobe edge; that value is also what is held
    assign act_ok  = vmc_hold_cond(mem_enable, link.volt_low, block_in)
                   & (~phase_overcurrent_condition | link.cur_high);
    assign keep_ok = vmc_hold_cond(mem_enable, link.volt_low, block_in);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            block_sampled_ff <= 1'b0;
        end else if (cycle_start) begin
            block_sampled_ff <= block_in;
        end
    end

    // ==========================================================
    // Definite-time hold timer
    logic [SCW-1:0] step_cnt_ff;
    logic [TW-1:0]  unit_cnt_ff;
    logic           hold_expired;
    logic           step_tick;
    vmc_state_t     state_ff;
    vmc_state_t     nxt_state;

    // Checked on every clock, not only at strobes, so the limit keeps its resolution
    assign hold_expired = unit_cnt_ff >= hold_lim;
    assign step_tick    = step_cnt_ff == SCW'(HOLD_STEP_CLKS - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_cnt_ff <= '0;
        end else if (state_ff != VMC_ACTIVE || step_tick) begin
            // Cleared outside use so each activation starts a fresh delay
            step_cnt_ff <= '0;
        end else begin
            step_cnt_ff <= step_cnt_ff + SCW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_cnt_ff <= '0;
        end else if (state_ff != VMC_ACTIVE) begin
            unit_cnt_ff <= '0;
        end else if (step_tick && !hold_expired) begin
            // Held at the limit so a long fault cannot wrap the count
            unit_cnt_ff <= unit_cnt_ff + TW'(1);
        end
    end

    // ==========================================================
    // Memory state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            VMC_IDLE: begin
                if (cycle_start && act_ok) begin
                    nxt_state = VMC_ACTIVE;
                end
            end
            VMC_ACTIVE: begin
                // A failing strobe wins over expiry, giving a plain end
                if (cycle_start && !keep_ok) begin
                    nxt_state = VMC_IDLE;
                end else if (hold_expired) begin
                    nxt_state = VMC_EXPIRED;
                end
            end
            VMC_EXPIRED: begin
                // Stays expired until the fault condition clears, no re-arm mid-fault
                if (cycle_start && !keep_ok) begin
                    nxt_state = VMC_IDLE;
                end
            end
            default: begin
                nxt_state = VMC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= VMC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_active_ff <= 1'b0;
        end else begin
            mem_active_ff <= nxt_state == VMC_ACTIVE;
        end
    end

    // Tells the directional stages to trip without direction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nondir_fallback_ff <= 1'b0;
        end else begin
            nondir_fallback_ff <= nxt_state == VMC_EXPIRED;
        end
    end

    // ==========================================================
    // Reference amplitude and angle
    logic [AW-1:0] prev_ang_ff;

    // Angle of the last healthy program cycle; frozen once the fault is seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_ang_ff <= '0;
        end else if (cycle_start && state_ff == VMC_IDLE && !act_ok) begin
            prev_ang_ff <= volt_ang_live;
        end
    end

    // Outside use the live angle passes through one clock late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_ang_ff <= '0;
        end else if (state_ff != VMC_ACTIVE && nxt_state == VMC_ACTIVE) begin
            ref_ang_ff <= prev_ang_ff;
        end else if (nxt_state != VMC_ACTIVE) begin
            ref_ang_ff <= volt_ang_live;
        end
    end

    // Outside use channel 0 of the chosen set is passed on as a plain magnitude
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_amp_ff <= '0;
        end else if (nxt_state == VMC_ACTIVE) begin
            ref_amp_ff <= volt_thr;
        end else begin
            ref_amp_ff <= sel_mag[0];
        end
    end

    // ==========================================================
    // Sampling frequency selection
    logic nxt_fct;

    // Current condition not needed: voltage loss alone leaves no frequency source
    assign nxt_fct = forced_ct_tracking & mem_enable & link.volt_low;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_from_ct_ff <= 1'b0;
        end else if (cycle_start) begin
            freq_from_ct_ff <= nxt_fct;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_freq_ff <= '0;
        end else if (freq_from_ct_ff) begin
            sample_freq_ff <= third_phase_current_freq;
        end else begin
            sample_freq_ff <= fixed_freq;
        end
    end

    // ==========================================================
    // Event levels, sampled once per program cycle except in-use, which follows mem_active_ff on every clock
    logic en_ff;
    logic vlow_ff;
    logic ihigh_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_ff <= 1'b0;
        end else if (cycle_start) begin
            en_ff <= mem_enable;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vlow_ff <= 1'b0;
        end else if (cycle_start) begin
            vlow_ff <= link.volt_low;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ihigh_ff <= 1'b0;
        end else if (cycle_start) begin
            ihigh_ff <= link.cur_high;
        end
    end

    assign link.levels[EV_ENABLED] = en_ff;
    assign link.levels[EV_VLOW]    = vlow_ff;
    assign link.levels[EV_IHIGH]   = ihigh_ff;
    assign link.levels[EV_FCT]     = freq_from_ct_ff;
    assign link.levels[EV_INUSE]   = mem_active_ff;
    assign link.levels[EV_BLOCKED] = block_sampled_ff;

    vmc_evt u_evt (
        .clk  (clk),
        .rst  (rst),
        .link (link.evt)
    );

    assign vt_module_event_block_on  = link.ev_on;
    assign vt_module_event_block_off = link.ev_off;

endmodule

// File: testbench/vmc_properties.sv
// Concurrent checks on the voltage memory controller top-level ports.
// Assumes it is bound to the top module and shares its hold step parameter.
module vmc_properties
    import vmc_pkg::*;
#(
    parameter int HOLD_STEP_CLKS = 4
)
(
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  cycle_start,
    input wire logic                  mem_enable,
    input wire logic                  line_to_line_sel,
    input wire vmc_pkg::vmc_mag_t     volt_ll_mag,
    input wire vmc_pkg::vmc_mag_t     volt_ln_mag,
    input wire logic [2:0]            volt_used,
    input wire vmc_pkg::vmc_mag_t     cur_mag,
    input wire logic                  phase_overcurrent_condition,
    input wire logic [15:0]           cur_pickup,
    input wire logic [15:0]           act_volt_set,
    input wire logic [12:0]           hold_time_limit,
    input wire logic [16:0]           fixed_freq,
    input wire logic [16:0]           third_phase_current_freq,
    input wire logic                  block_in,
    input wire logic                  mem_active_ff,
    input wire logic [15:0]           ref_amp_ff,
    input wire logic [15:0]           ref_ang_ff,
    input wire logic                  nondir_fallback_ff,
    input wire logic                  block_sampled_ff,
    input wire logic                  freq_from_ct_ff,
    input wire logic [16:0]           sample_freq_ff,
    input wire logic [5:0]            vt_module_event_block_on
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // Reference conditions, worked out independently of the design
    logic [15:0]     thr;
    logic            vlow;
    logic            chigh;
    vmc_mag_t        sel;
    logic [23:0]     lim;
    logic [23:0]     act_cnt_ff;
    assign lim = 24'(hold_time_limit) * 24'(HOLD_STEP_CLKS);
    always_comb begin
        thr = (act_volt_set < 16'h00C8) ? 16'h00C8 : ((act_volt_set > 16'h1388) ? 16'h1388 : act_volt_set);
        sel = line_to_line_sel ? volt_ll_mag : volt_ln_mag;
        vlow = |volt_used;
        chigh = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (volt_used[i] && sel[i] >= thr) begin
                vlow = 1'b0;
            end
            if (cur_mag[i] > cur_pickup) begin
                chigh = 1'b1;
            end
        end
    end
    // Counts clocks spent in use, so the expiry moment can be judged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_cnt_ff <= '0;
        end else begin
            act_cnt_ff <= mem_active_ff ? act_cnt_ff + 24'h1 : '0;
        end
    end
    // ====
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_start_cause: assert property ($rose(mem_active_ff) |->
        $past(cycle_start && mem_enable && vlow && !block_in)) else $error("memory started without cause");
    a_start_current: assert property ($rose(mem_active_ff) && $past(phase_overcurrent_condition) |->
        $past(chigh)) else $error("memory started without high current");
    a_amp_subst: assert property (mem_active_ff |-> ref_amp_ff == $past(thr))
        else $error("reference amplitude not the activation setting");
    a_angle_held: assert property (mem_active_ff && $past(mem_active_ff) |-> $stable(ref_ang_ff))
        else $error("reference angle moved while in use");
    a_end_cause: assert property ($fell(mem_active_ff) && !nondir_fallback_ff |->
        $past(cycle_start) && !$past(mem_enable && vlow && !block_in)) else $error("memory ended without cause");
    a_expiry_time: assert property ($rose(nondir_fallback_ff) |->
        act_cnt_ff >= lim && act_cnt_ff <= lim + 24'h1) else $error("hold limit expiry at wrong time");
    a_fallback_src: assert property ($rose(nondir_fallback_ff) |->
        $past(mem_active_ff) && !mem_active_ff) else $error("fallback not entered from use");
    a_block_sample: assert property (cycle_start |=> block_sampled_ff == $past(block_in))
        else $error("blocking not captured at cycle start");
    a_freq_select: assert property (!$past(rst) |->
        sample_freq_ff == ($past(freq_from_ct_ff) ? $past(third_phase_current_freq) : $past(fixed_freq)))
        else $error("sampling frequency source wrong");
    a_use_event: assert property (vt_module_event_block_on[EV_INUSE] |->
        $past(mem_active_ff) && !$past(mem_active_ff, 2)) else $error("in-use event without start");
    c_start: cover property ($rose(mem_active_ff));
    c_expire: cover property ($rose(nondir_fallback_ff));
    c_ct_freq: cover property ($rose(freq_from_ct_ff));
endmodule

bind vmc_pre_fault_reference_hold vmc_properties #(.HOLD_STEP_CLKS(HOLD_STEP_CLKS)) chk_u (
    .clk, .rst, .cycle_start, .mem_enable, .line_to_line_sel, .volt_ll_mag, .volt_ln_mag, .volt_used,
    .cur_mag, .phase_overcurrent_condition, .cur_pickup, .act_volt_set, .hold_time_limit, .fixed_freq,
    .third_phase_current_freq, .block_in, .mem_active_ff, .ref_amp_ff, .ref_ang_ff, .nondir_fallback_ff,
    .block_sampled_ff, .freq_from_ct_ff, .sample_freq_ff, .vt_module_event_block_on);

// File: testbench/vmc_front_end_model.sv
// Program cycle strobe source standing in for the measurement front end.
// Assumes one clock; the strobe is one clock wide every CYCLE_CLKS clocks.
module vmc_front_end_model #(
    parameter int CYCLE_CLKS = 4
)
(
    input  wire logic clk,
    input  wire logic rst,
    output logic      cycle_start
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff      <= '0;
            cycle_start <= 1'b0;
        end else begin
            cnt_ff      <= (cnt_ff == 4'(CYCLE_CLKS - 1)) ? 4'h0 : cnt_ff + 4'h1;
            cycle_start <= (cnt_ff == 4'h0);
        end
    end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the voltage memory controller.
// Assumes the front end model supplies program cycle strobes.
module tb_top
    import vmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, cycle_start, mem_enable, line_to_line_sel, phase_overcurrent_condition;
    logic        forced_ct_tracking, block_in, mem_active_ff, nondir_fallback_ff, block_sampled_ff;
    logic        freq_from_ct_ff;
    vmc_mag_t    volt_ll_mag, volt_ln_mag, cur_mag;
    logic [2:0]  volt_used;
    logic [15:0] volt_ang_live, cur_pickup, act_volt_set, ref_amp_ff, ref_ang_ff;
    logic [12:0] hold_time_limit;
    logic [16:0] fixed_freq, third_phase_current_freq, sample_freq_ff;
    logic [5:0]  vt_module_event_block_on, vt_module_event_block_off, seen_on, seen_off;
    int          failures = 0;
    int          checked = 0;

    vmc_front_end_model fe_u (.clk, .rst, .cycle_start);
    vmc_pre_fault_reference_hold #(.HOLD_STEP_CLKS(4)) dut_u (
        .clk, .rst, .cycle_start, .mem_enable, .line_to_line_sel, .volt_ll_mag, .volt_ln_mag, .volt_used,
        .volt_ang_live, .cur_mag, .phase_overcurrent_condition, .cur_pickup, .act_volt_set, .hold_time_limit,
        .forced_ct_tracking, .fixed_freq, .third_phase_current_freq, .block_in, .mem_active_ff, .ref_amp_ff,
        .ref_ang_ff, .nondir_fallback_ff, .block_sampled_ff, .freq_from_ct_ff, .sample_freq_ff,
        .vt_module_event_block_on, .vt_module_event_block_off);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Sticky record of every event pulse seen
    always @(posedge clk) begin
        seen_on  <= rst ? 6'h00 : seen_on | vt_module_event_block_on;
        seen_off <= rst ? 6'h00 : seen_off | vt_module_event_block_off;
    end

    task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Two strobes after a change guarantee one saw the new inputs
    task automatic step(input int n);
        repeat (n) @(posedge clk iff cycle_start);
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic report_and_stop();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        mem_enable = 1'b1;
        line_to_line_sel = 1'b0;
        volt_ll_mag = {3{16'h2710}};
        volt_ln_mag = {3{16'h2710}};
        volt_used = 3'h7;
        volt_ang_live = 16'h1234;
        cur_mag = '0;
        phase_overcurrent_condition = 1'b0;
        cur_pickup = 16'h0100;
        act_volt_set = 16'h0BB8;
        hold_time_limit = 13'h0032;
        forced_ct_tracking = 1'b0;
        fixed_freq = 17'h0C350;
        third_phase_current_freq = 17'h0B3B0;
        block_in = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        step(2);
        chk("freq", sample_freq_ff, 17'h0C350);
        @(posedge clk);
        volt_ln_mag <= {16'h2710, 16'h0064, 16'h0064};
        step(2);
        chk("active", mem_active_ff, 0);
        @(posedge clk);
        volt_used <= 3'h3;
        volt_ang_live <= 16'h0FFF;
        step(2);
        chk("active", mem_active_ff, 1);
        chk("amp", ref_amp_ff, 16'h0BB8);
        chk("angle", ref_ang_ff, 16'h1234);
        @(posedge clk);
        volt_ln_mag <= {3{16'h2710}};
        step(2);
        chk("active", mem_active_ff, 0);
        @(posedge clk);
        volt_ln_mag <= {3{16'h0064}};
        volt_used <= 3'h7;
        forced_ct_tracking <= 1'b1;
        step(2);
        chk("freq", sample_freq_ff, 17'h0B3B0);
        chk("ct flag", freq_from_ct_ff, 1);
        @(posedge clk);
        block_in <= 1'b1;
        step(2);
        chk("active", mem_active_ff, 0);
        chk("blocked", block_sampled_ff, 1);
        @(posedge clk);
        hold_time_limit <= 13'h0002;
        block_in <= 1'b0;
        repeat (24) @(posedge clk);
        @(negedge clk);
        chk("fallback", nondir_fallback_ff, 1);
        chk("active", mem_active_ff, 0);
        chk("amp", ref_amp_ff, 16'h0064);
        chk("angle", ref_ang_ff, 16'h0FFF);
        @(posedge clk);
        volt_ln_mag <= {3{16'h2710}};
        phase_overcurrent_condition <= 1'b1;
        cur_mag <= {16'h0000, 16'h0000, 16'h0100};
        step(2);
        chk("fallback", nondir_fallback_ff, 0);
        chk("freq", sample_freq_ff, 17'h0C350);
        @(posedge clk);
        volt_ln_mag <= {3{16'h0064}};
        step(2);
        chk("active", mem_active_ff, 0);
        @(posedge clk);
        cur_mag[0] <= 16'h0101;
        step(2);
        chk("active", mem_active_ff, 1);
        @(posedge clk);
        mem_enable <= 1'b0;
        step(2);
        chk("active", mem_active_ff, 0);
        @(posedge clk);
        mem_enable <= 1'b1;
        phase_overcurrent_condition <= 1'b0;
        cur_mag <= '0;
        act_volt_set <= 16'h0010;
        volt_ln_mag <= {3{16'h00C7}};
        step(2);
        chk("active", mem_active_ff, 1);
        chk("amp", ref_amp_ff, 16'h00C8);
        @(posedge clk);
        volt_ln_mag <= {3{16'h2710}};
        step(2);
        chk("events on", seen_on, 6'h3F);
        chk("events off", seen_off, 6'h3F);
        report_and_stop();
    end

    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule
